// >>> rtl/bridge_regs_pkg.sv
// constants of the bridge command/status register pair and its bus slave
// assumes a 32-bit AHB-Lite register bus and one core clock
package bridge_regs_pkg;
  localparam int ADDR_W = 8;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] CMD_IDX = 8'h04;
  localparam logic [ADDR_W-1:0] STS_IDX = 8'h06;
  localparam logic [ADDR_W-1:0] CMD_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] STS_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h24;
  // bridge_command fields
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_SERR_BIT = 8;
  localparam logic [15:0] CMD_RW_MASK = 16'h0107;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // bridge_status fields
  localparam int STS_SERR_BIT = 14;
  localparam logic [15:0] STS_FIXED = 16'h00a0;
  localparam logic [15:0] STS_RESET = 16'h00a0;
  // interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_SERR_BIT = 0;
  localparam int IRQ_MEM_DENY_BIT = 1;
  localparam int IRQ_IO_DENY_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_DONE = 2'b10
  } bus_state_e;
endpackage

// >>> rtl/sticky_flags.sv
// sticky event flags with a set that always beats a clear in the same cycle
// assumes set and clr are one-cycle strobes in the clk domain
`timescale 1ns/10ps
module sticky_flags #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  logic [W-1:0] flags_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~clr) | set;
    end
  end

  assign flags = flags_reg;
endmodule

// >>> rtl/bridge_command_status_regs.sv
// command/status register pair of the bridge function, with its AHB-Lite slave
// assumes window hits and the bridge error event come synchronous to clk
`timescale 1ns/10ps
module bridge_command_status_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic mem_window_hit,
  input wire logic prefetch_window_hit,
  input wire logic io_window_hit,
  input wire logic bridge_err_event,
  output logic mem_claim,
  output logic prefetch_claim,
  output logic io_claim,
  output logic syserr_msg_req,
  output logic irq
);
  import bridge_regs_pkg::*;

  bus_state_e state_reg;
  bus_state_e state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic write_reg;
  logic [31:0] hrdata_reg;
  logic [15:0] command_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic mem_claim_reg;
  logic prefetch_claim_reg;
  logic io_claim_reg;
  logic msg_req_reg;
  logic irq_reg;
  logic addr_phase;
  logic do_write;
  logic do_read;
  logic sse_flag;
  logic sse_clr;
  logic [IRQ_W-1:0] irq_flags;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [15:0] status_value;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // bus slave: one wait cycle lets read data come from a flop and keeps
  // a write's effect visible to a read issued right behind it
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign do_write = (state_reg == ST_ACCESS) && write_reg;
  assign do_read = (state_reg == ST_ACCESS) && !write_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (addr_phase) begin
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = addr_phase ? ST_ACCESS : ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg <= '0;
      write_reg <= 1'b0;
    end else if (addr_phase && state_reg != ST_ACCESS) begin
      addr_reg <= haddr[ADDR_W-1:0];
      write_reg <= hwrite;
    end
  end

  assign hreadyout = (state_reg != ST_ACCESS);
  assign hresp = 1'b0;

  // fixed capability bits sit under the single live bit
  // fixed status bits
  always_comb begin
    status_value = STS_FIXED;
    status_value[STS_SERR_BIT] = sse_flag;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata_reg <= '0;
    end else if (do_read) begin
      if (hit(addr_reg, CMD_ADDR)) begin
        hrdata_reg <= {16'h0000, command_reg & CMD_RW_MASK};
      end else if (hit(addr_reg, STS_ADDR)) begin
        hrdata_reg <= {16'h0000, status_value};
      end else if (hit(addr_reg, IRQ_STATUS_ADDR)) begin
        hrdata_reg <= {29'h0, irq_flags};
      end else if (hit(addr_reg, IRQ_MASK_ADDR)) begin
        hrdata_reg <= {29'h0, irq_mask_reg};
      end else begin
        hrdata_reg <= '0;
      end
    end
  end

  assign hrdata = hrdata_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      command_reg <= CMD_RESET;
    end else if (do_write && hit(addr_reg, CMD_ADDR)) begin
      command_reg <= hwdata[15:0] & CMD_RW_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (do_write && hit(addr_reg, IRQ_MASK_ADDR)) begin
      irq_mask_reg <= hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_claim_reg <= 1'b0;
      prefetch_claim_reg <= 1'b0;
      io_claim_reg <= 1'b0;
    end else begin
      mem_claim_reg <= mem_window_hit && command_reg[CMD_MEM_BIT];
      prefetch_claim_reg <= prefetch_window_hit && command_reg[CMD_MEM_BIT];
      io_claim_reg <= io_window_hit && command_reg[CMD_IO_BIT];
    end
  end

  assign mem_claim = mem_claim_reg;
  assign prefetch_claim = prefetch_claim_reg;
  assign io_claim = io_claim_reg;

  // only this function's enable is consulted; the host function has its own
  // message enable
  always_ff @(posedge clk) begin
    if (reset) begin
      msg_req_reg <= 1'b0;
    end else begin
      msg_req_reg <= bridge_err_event && command_reg[CMD_SERR_BIT];
    end
  end

  assign syserr_msg_req = msg_req_reg;

  assign sse_clr = do_write && hit(addr_reg, STS_ADDR) && hwdata[STS_SERR_BIT];

  sticky_flags #(
    .W(1)
  ) sse_flags (
    .clk(clk),
    .reset(reset),
    .set(msg_req_reg),
    .clr(sse_clr),
    .flags(sse_flag)
  );

  // read of the interrupt status clears it; events landing that cycle survive
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SERR_BIT] = msg_req_reg;
    irq_set[IRQ_MEM_DENY_BIT] = (mem_window_hit || prefetch_window_hit) && !command_reg[CMD_MEM_BIT];
    irq_set[IRQ_IO_DENY_BIT] = io_window_hit && !command_reg[CMD_IO_BIT];
    irq_clr = (do_read && hit(addr_reg, IRQ_STATUS_ADDR)) ? '1 : '0;
  end

  sticky_flags #(
    .W(IRQ_W)
  ) irq_status_flags (
    .clk(clk),
    .reset(reset),
    .set(irq_set),
    .clr(irq_clr),
    .flags(irq_flags)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_flags & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // checks

  serr_enable_a: assert property (
    @(posedge clk) disable iff (reset)
    bridge_err_event && command_reg[CMD_SERR_BIT] |=> syserr_msg_req)
    else $error("enabled error event sent no system-error message");

  serr_block_a: assert property (
    @(posedge clk) disable iff (reset)
    !$past(command_reg[CMD_SERR_BIT]) |-> !syserr_msg_req)
    else $error("system-error message sent while this function is disabled");

  mem_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    ##1 (mem_claim || prefetch_claim) |-> $past(command_reg[CMD_MEM_BIT]))
    else $error("memory window claimed while memory space disabled");

  mem_pass_a: assert property (
    @(posedge clk) disable iff (reset)
    mem_window_hit && command_reg[CMD_MEM_BIT] |=> mem_claim)
    else $error("enabled memory window hit not claimed");

  io_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    io_window_hit |=> (io_claim == $past(command_reg[CMD_IO_BIT])))
    else $error("io claim does not follow io space enable");

  master_store_a: assert property (
    @(posedge clk) disable iff (reset)
    do_write && hit(addr_reg, CMD_ADDR) |=> command_reg[CMD_MASTER_BIT] == $past(hwdata[CMD_MASTER_BIT]))
    else $error("bus master bit does not store the written value");

  cmd_zero_a: assert property (
    @(posedge clk) disable iff (reset)
    do_read && hit(addr_reg, CMD_ADDR) |=> hrdata[15:9] == 7'h00 && hrdata[7:3] == 5'h00 && hreadyout)
    else $error("hardwired command bits read nonzero");

  sse_set_a: assert property (
    @(posedge clk) disable iff (reset)
    syserr_msg_req |=> sse_flag)
    else $error("signalled system error not flagged after message");

  sse_keep_a: assert property (
    @(posedge clk) disable iff (reset)
    sse_flag && !sse_clr |=> sse_flag)
    else $error("signalled system error lost without a clearing write");

  sts_fixed_a: assert property (
    @(posedge clk) disable iff (reset)
    do_read && hit(addr_reg, STS_ADDR) |=> hrdata[10:9] == 2'b00 && hrdata[7] && hrdata[5])
    else $error("status capability bits read wrong");

  sts_zero_a: assert property (
    @(posedge clk) disable iff (reset)
    do_read && hit(addr_reg, STS_ADDR) |=> !hrdata[15] && hrdata[13:11] == 3'h0 && !hrdata[8])
    else $error("unimplemented status bits read nonzero");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (reset)
    do_read |=> hrdata[31:16] == 16'h0000 && hreadyout)
    else $error("upper read data not zero");

  ready_wait_a: assert property (
    @(posedge clk) disable iff (reset)
    addr_phase && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("data phase length is not two cycles");

  irq_level_a: assert property (
    @(posedge clk) disable iff (reset)
    |(irq_flags & irq_mask_reg) |=> irq)
    else $error("interrupt not raised for unmasked status");

  irq_drop_a: assert property (
    @(posedge clk) disable iff (reset)
    !(|(irq_flags & irq_mask_reg)) |=> !irq)
    else $error("interrupt high with no unmasked status");

  prefetch_pass_a: assert property (
    @(posedge clk) disable iff (reset)
    prefetch_window_hit && command_reg[CMD_MEM_BIT] |=> prefetch_claim)
    else $error("enabled prefetchable window hit not claimed");

  sse_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    sse_flag && sse_clr && !msg_req_reg |=> !sse_flag)
    else $error("writing one did not clear signalled system error");

  sts_readback_a: assert property (
    @(posedge clk) disable iff (reset)
    do_read && hit(addr_reg, STS_ADDR) |=> hrdata[STS_SERR_BIT] == $past(sse_flag))
    else $error("status read does not show signalled system error");

  cmd_readback_a: assert property (
    @(posedge clk) disable iff (reset)
    do_read && hit(addr_reg, CMD_ADDR) |=> hrdata[15:0] == $past(command_reg))
    else $error("command read does not return stored bits");

  serr_sent_c: cover property (
    @(posedge clk) disable iff (reset)
    syserr_msg_req ##[1:20] sse_clr);

  mem_claim_c: cover property (
    @(posedge clk) disable iff (reset)
    mem_claim ##1 io_claim);

  irq_raise_c: cover property (
    @(posedge clk) disable iff (reset)
    irq ##[1:10] !irq);

  sse_race_c: cover property (
    @(posedge clk) disable iff (reset)
    msg_req_reg && sse_clr);

  io_deny_c: cover property (
    @(posedge clk) disable iff (reset)
    io_window_hit && !command_reg[CMD_IO_BIT] ##2 irq);
endmodule

// >>> verif/testbench.sv
// self-checking bench for the bridge command/status register pair
// assumes one 200 MHz clock and the one-wait-state AHB-Lite slave of the design
`timescale 1ns/10ps
module testbench;
  import bridge_regs_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} row_s;
  logic clk, reset, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic mh, ph, ih, ev, mc, pc, ic, sm;
  int err_total = 0;
  int samples_checked = 0;
  row_s rows [12];

  bridge_command_status_regs i_bridge_command_status_regs (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .mem_window_hit(mh), .prefetch_window_hit(ph), .io_window_hit(ih),
    .bridge_err_event(ev), .mem_claim(mc), .prefetch_claim(pc), .io_claim(ic),
    .syserr_msg_req(sm), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for hreadyout sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask

  // next transfer may start right away, so calls run back to back
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk_word(rd, exp);
    chk_port({3'h0, hresp}, 4'h0);
  endtask

  // one-cycle pulse on {mem, prefetch, io, error}; claims and request seen one cycle later
  task automatic side(input logic [3:0] in, input logic [3:0] exp);
    {mh, ph, ih, ev} <= in;
    @(posedge clk);
    {mh, ph, ih, ev} <= 4'h0;
    @(posedge clk);
    chk_port({mc, pc, ic, sm}, exp);
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {mh, ph, ih, ev} = 4'h0;
    rows = '{'{1'b1, CMD_ADDR, 32'hffff_ffff}, '{1'b0, CMD_ADDR, 32'h0000_0107},
             '{1'b1, CMD_ADDR, 32'h0000_0104}, '{1'b0, CMD_ADDR, 32'h0000_0104},
             '{1'b1, STS_ADDR, 32'hffff_ffff}, '{1'b0, STS_ADDR, 32'h0000_00a0},
             '{1'b1, 8'h40, 32'hffff_ffff}, '{1'b0, 8'h40, 32'h0},
             '{1'b1, IRQ_MASK_ADDR, 32'h7}, '{1'b0, IRQ_MASK_ADDR, 32'h7},
             '{1'b1, IRQ_MASK_ADDR, 32'h0}, '{1'b0, IRQ_MASK_ADDR, 32'h0}};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_port({mc, pc, ic, sm}, 4'h0);
    chk_port({3'h0, irq}, 4'h0);
    rd_chk(CMD_ADDR, 32'h0);
    rd_chk(STS_ADDR, 32'h0000_00a0);
    rd_chk(IRQ_MASK_ADDR, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd_chk(rows[i].a, rows[i].d);
      end
    end
    wr(CMD_ADDR, 32'h3);
    side(4'hf, 4'he);
    rd_chk(STS_ADDR, 32'h0000_00a0);
    wr(CMD_ADDR, 32'h4);
    side(4'he, 4'h0);
    rd_chk(IRQ_STATUS_ADDR, 32'h6);
    chk_port({3'h0, irq}, 4'h0);
    rd_chk(IRQ_STATUS_ADDR, 32'h0);
    wr(IRQ_MASK_ADDR, 32'h1);
    wr(CMD_ADDR, 32'h100);
    side(4'h1, 4'h1);
    rd_chk(STS_ADDR, 32'h0000_40a0);
    chk_port({3'h0, irq}, 4'h1);
    wr(STS_ADDR, 32'h0000_bfff);
    rd_chk(STS_ADDR, 32'h0000_40a0);
    wr(STS_ADDR, 32'h0000_4000);
    rd_chk(STS_ADDR, 32'h0000_00a0);
    rd_chk(IRQ_STATUS_ADDR, 32'h1);
    repeat (2) @(posedge clk);
    chk_port({3'h0, irq}, 4'h0);
    // error event meets the clearing write in the same cycle: the set must win
    fork
      wr(STS_ADDR, 32'h0000_4000);
      begin
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
      end
    join
    rd_chk(STS_ADDR, 32'h0000_40a0);
    chk_port({3'h0, irq}, 4'h1);
    // reset in mid-run brings every register back to its default
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_port({mc, pc, ic, sm}, 4'h0);
    chk_port({3'h0, irq}, 4'h0);
    rd_chk(CMD_ADDR, 32'h0);
    rd_chk(STS_ADDR, 32'h0000_00a0);
    rd_chk(IRQ_STATUS_ADDR, 32'h0);
    rd_chk(IRQ_MASK_ADDR, 32'h0);
    print_verdict();
  end
endmodule
